/* far_side_model.sv */
`timescale 1ns/1ps
module far_side_model (
  input wire logic pclk,
  input wire logic pulse_req,
  input wire logic [7:0] pulse_len,
  input wire logic wake_req,
  output logic ext_power_event_in_n,
  output logic activity_wake
);
  logic [7:0] left = 8'h00;
  logic wake_q = 1'b0;
  // The event pin idles high on its pull-up and is pulled low for the asked number of cycles.
  always @(posedge pclk) begin
    if (pulse_req) begin
      left <= pulse_len;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
    wake_q <= wake_req;
  end
  assign ext_power_event_in_n = (left == 8'h00);
  assign activity_wake = wake_q;
endmodule

/* low_power_mode_control_regs.sv */
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
module low_power_mode_control_regs #(
  parameter longint cycles_per_second = pm_regs_pkg::CYCLES_PER_SECOND,
  parameter longint long_pulse_cycles = pm_regs_pkg::LONG_PULSE_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pm_regs_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_power_event_in_n,
  input wire logic activity_wake,
  output logic periph_power_en_n,
  output logic mgmt_interrupt_n,
  output logic irq15,
  output logic sleep_out_bit0_n,
  output logic sleep_out_bit1_n,
  output logic sleep_out_bit2_n,
  output logic wake_out_bit1_n,
  output logic wake_out_bit2_n,
  output logic low_power_active,
  output logic pm_irq
);

  localparam int PRE_W = $clog2(cycles_per_second + 1);
  localparam int DEB_W = $clog2(long_pulse_cycles + pm_regs_pkg::SHORT_PULSE_CYCLES + 1);

  generate
    if (cycles_per_second < 2 || long_pulse_cycles < 1) begin : bad_params
      $error("cycles_per_second must be at least 2 and long_pulse_cycles at least 1");
    end
  endgenerate

  function automatic logic [pm_regs_pkg::SECONDS_W-1:0] period_seconds(
      input logic [pm_regs_pkg::TIMER_SEL_W-1:0] sel);
    logic [pm_regs_pkg::SECONDS_W-1:0] s;
    s = '0;
    unique case (sel)
      3'h0: s = pm_regs_pkg::SECONDS_W'(pm_regs_pkg::TIMER_S_0);
      3'h1: s = pm_regs_pkg::SECONDS_W'(pm_regs_pkg::TIMER_S_1);
      3'h2: s = pm_regs_pkg::SECONDS_W'(pm_regs_pkg::TIMER_S_2);
      3'h3: s = pm_regs_pkg::SECONDS_W'(pm_regs_pkg::TIMER_S_3);
      3'h4: s = pm_regs_pkg::SECONDS_W'(pm_regs_pkg::TIMER_S_4);
      3'h5: s = pm_regs_pkg::SECONDS_W'(pm_regs_pkg::TIMER_S_5);
      3'h6: s = pm_regs_pkg::SECONDS_W'(pm_regs_pkg::TIMER_S_6);
      3'h7: s = pm_regs_pkg::SECONDS_W'(pm_regs_pkg::TIMER_S_7);
    endcase
    return s;
  endfunction

  function automatic logic hits(input logic [pm_regs_pkg::ADDR_W-1:0] a, input logic [7:0] idx);
    return a == {idx, 2'b00};
  endfunction

  logic [7:0] entry_ctl;
  logic [2:0] cause;
  logic [7:0] mode_timer;
  logic [7:0] low_power_output_config;
  logic [7:0] normal_return_output_config;
  logic [7:0] scratch_one;
  logic [7:0] scratch_two;
  logic [7:0] wake_source_options;
  logic [7:0] companion_chip_select;
  logic [pm_regs_pkg::IRQ_W-1:0] irq_status;
  logic [pm_regs_pkg::IRQ_W-1:0] irq_enable;
  pm_regs_pkg::mode_state_type mode_state;

  logic wr;
  logic setup_rd;
  logic mapped;
  logic [7:0] next_rdata;
  assign wr = psel && penable && pwrite;
  assign setup_rd = psel && !penable && !pwrite;

  always_comb begin
    mapped = 1'b1;
    next_rdata = 8'h00;
    if (hits(paddr, pm_regs_pkg::ENTRY_CTL_IDX)) begin
      next_rdata = {entry_ctl[7:4], mode_state == pm_regs_pkg::normal_state, cause};
    end else if (hits(paddr, pm_regs_pkg::MODE_TIMER_IDX)) begin
      next_rdata = mode_timer;
    end else if (hits(paddr, pm_regs_pkg::LOW_POWER_OUT_IDX)) begin
      next_rdata = low_power_output_config;
    end else if (hits(paddr, pm_regs_pkg::NORMAL_OUT_IDX)) begin
      next_rdata = normal_return_output_config;
    end else if (hits(paddr, pm_regs_pkg::SCRATCH_ONE_IDX)) begin
      next_rdata = scratch_one;
    end else if (hits(paddr, pm_regs_pkg::SCRATCH_TWO_IDX)) begin
      next_rdata = scratch_two;
    end else if (hits(paddr, pm_regs_pkg::WAKE_OPT_IDX)) begin
      next_rdata = wake_source_options;
    end else if (hits(paddr, pm_regs_pkg::COMPANION_IDX)) begin
      next_rdata = companion_chip_select;
    end else if (hits(paddr, pm_regs_pkg::IRQ_STATUS_IDX)) begin
      next_rdata = {6'h00, irq_status};
    end else if (hits(paddr, pm_regs_pkg::IRQ_ENABLE_IDX)) begin
      next_rdata = {6'h00, irq_enable};
    end else if (hits(paddr, pm_regs_pkg::IRQ_CLEAR_IDX)) begin
      next_rdata = 8'h00;
    end else begin
      mapped = 1'b0;
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Read data is captured in the setup cycle so that it comes from a flip-flop in the access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup_rd) begin
      prdata <= {24'h000000, next_rdata};
    end
  end

  // External power-event input: synchroniser, polarity and pulse-width filter.
  logic ext_meta;
  logic ext_sync;
  logic ext_active;
  logic [DEB_W-1:0] deb_count;
  logic [DEB_W-1:0] deb_limit;
  logic ext_event;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_meta <= 1'b1;
      ext_sync <= 1'b1;
    end else begin
      ext_meta <= ext_power_event_in_n;
      ext_sync <= ext_meta;
    end
  end

  assign ext_active = mode_timer[pm_regs_pkg::POLARITY_BIT] ? ext_sync : !ext_sync;
  assign deb_limit = mode_timer[pm_regs_pkg::PULSE_WIDTH_BIT] ? DEB_W'(long_pulse_cycles) :
                     DEB_W'(pm_regs_pkg::SHORT_PULSE_CYCLES);
  assign ext_event = ext_active && (deb_count == deb_limit - DEB_W'(1));

  // The count stops at the limit, one past the event count, so that a long pulse gives a single event.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deb_count <= '0;
    end else if (!ext_active) begin
      deb_count <= '0;
    end else if (deb_count < deb_limit) begin
      deb_count <= deb_count + DEB_W'(1);
    end
  end

  // Entry and wake decisions.
  logic timeout;
  logic force_write;
  logic timer_entry;
  logic ext_entry;
  logic force_entry;
  logic enter;
  logic wake;
  logic in_normal;
  logic reload;
  assign in_normal = mode_state == pm_regs_pkg::normal_state;
  assign force_write = wr && hits(paddr, pm_regs_pkg::MODE_TIMER_IDX) && pwdata[pm_regs_pkg::FORCE_BIT];
  assign timer_entry = in_normal && timeout && entry_ctl[pm_regs_pkg::TIMER_BIT];
  assign ext_entry = in_normal && ext_event && entry_ctl[pm_regs_pkg::EXT_BIT];
  assign force_entry = in_normal && force_write && entry_ctl[pm_regs_pkg::FORCE_EN_BIT];
  assign enter = timer_entry || ext_entry || force_entry;
  assign wake = !in_normal && (activity_wake || (ext_event && mode_timer[pm_regs_pkg::EXT_RELOAD_BIT]));
  assign reload = wake || enter || (in_normal && (activity_wake ||
                  (ext_event && mode_timer[pm_regs_pkg::EXT_RELOAD_BIT])));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_state <= pm_regs_pkg::normal_state;
    end else begin
      unique case (mode_state)
        pm_regs_pkg::normal_state: if (enter) begin
          mode_state <= pm_regs_pkg::low_power_state;
        end
        pm_regs_pkg::low_power_state: if (wake) begin
          mode_state <= pm_regs_pkg::normal_state;
        end
      endcase
    end
  end

  // Event timer: a one-second prescaler and a seconds counter.
  logic [PRE_W-1:0] prescale;
  logic [pm_regs_pkg::SECONDS_W-1:0] event_timer;
  logic second_tick;
  assign second_tick = prescale == PRE_W'(cycles_per_second - 1);
  assign timeout = event_timer >= period_seconds(mode_timer[pm_regs_pkg::TIMER_SEL_W-1:0]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale <= '0;
    end else if (reload || second_tick) begin
      prescale <= '0;
    end else begin
      prescale <= prescale + PRE_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_timer <= '0;
    end else if (reload) begin
      event_timer <= '0;
    end else if (second_tick && !timeout) begin
      event_timer <= event_timer + pm_regs_pkg::SECONDS_W'(1);
    end
  end

  // Main power-control register: control bits and written enables.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      entry_ctl <= pm_regs_pkg::REG_RESET;
    end else if (wr && hits(paddr, pm_regs_pkg::ENTRY_CTL_IDX)) begin
      entry_ctl <= {pwdata[7:4], 1'b0, pwdata[2:0]};
    end
  end

  // Cause flags: writing 0 clears one, a new entry in the same cycle wins.
  logic [2:0] cause_set;
  logic [2:0] cause_clr;
  assign cause_set = {timer_entry, ext_entry, force_entry};
  assign cause_clr = (wr && hits(paddr, pm_regs_pkg::ENTRY_CTL_IDX)) ? ~pwdata[2:0] : 3'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause <= 3'h0;
    end else begin
      cause <= cause_set | (cause & ~cause_clr);
    end
  end

  // Force bit is a command and reads back as 0.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_timer <= pm_regs_pkg::REG_RESET;
    end else if (wr && hits(paddr, pm_regs_pkg::MODE_TIMER_IDX)) begin
      mode_timer <= pwdata[7:0] & ~(8'h01 << pm_regs_pkg::FORCE_BIT);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_power_output_config <= pm_regs_pkg::REG_RESET;
      normal_return_output_config <= pm_regs_pkg::REG_RESET;
      scratch_one <= pm_regs_pkg::REG_RESET;
      scratch_two <= pm_regs_pkg::REG_RESET;
      wake_source_options <= pm_regs_pkg::REG_RESET;
      companion_chip_select <= pm_regs_pkg::REG_RESET;
    end else if (wr) begin
      if (hits(paddr, pm_regs_pkg::LOW_POWER_OUT_IDX)) begin
        low_power_output_config <= pwdata[7:0];
      end
      if (hits(paddr, pm_regs_pkg::NORMAL_OUT_IDX)) begin
        normal_return_output_config <= pwdata[7:0];
      end
      if (hits(paddr, pm_regs_pkg::SCRATCH_ONE_IDX)) begin
        scratch_one <= pwdata[7:0];
      end
      if (hits(paddr, pm_regs_pkg::SCRATCH_TWO_IDX)) begin
        scratch_two <= pwdata[7:0];
      end
      if (hits(paddr, pm_regs_pkg::WAKE_OPT_IDX)) begin
        wake_source_options <= pwdata[7:0];
      end
      if (hits(paddr, pm_regs_pkg::COMPANION_IDX)) begin
        companion_chip_select <= pwdata[7:0];
      end
    end
  end

  // Interrupt status: sticky, set wins over a clear in the same cycle.
  logic [pm_regs_pkg::IRQ_W-1:0] irq_set;
  logic [pm_regs_pkg::IRQ_W-1:0] irq_clr;
  assign irq_set = {wake, enter};
  assign irq_clr = (wr && hits(paddr, pm_regs_pkg::IRQ_CLEAR_IDX)) ? pwdata[pm_regs_pkg::IRQ_W-1:0] :
                   pm_regs_pkg::IRQ_RESET;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= pm_regs_pkg::IRQ_RESET;
    end else begin
      irq_status <= irq_set | (irq_status & ~irq_clr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable <= pm_regs_pkg::IRQ_RESET;
    end else if (wr && hits(paddr, pm_regs_pkg::IRQ_ENABLE_IDX)) begin
      irq_enable <= pwdata[pm_regs_pkg::IRQ_W-1:0];
    end
  end

  // Outputs toward the processor and companion chip, all registered.
  logic next_low_power;
  logic cause_pending;
  assign next_low_power = (mode_state == pm_regs_pkg::low_power_state && !wake) || enter;
  assign cause_pending = |cause_set || |(cause & ~cause_clr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_power_en_n <= 1'b0;
      mgmt_interrupt_n <= 1'b1;
      irq15 <= 1'b0;
      low_power_active <= 1'b0;
      pm_irq <= 1'b0;
    end else begin
      // Power enable is released only in low-power mode and only if allowed.
      periph_power_en_n <= next_low_power && entry_ctl[pm_regs_pkg::PERIPH_GEN_BIT];
      // Management-interrupt entry signals software while a cause is pending.
      mgmt_interrupt_n <= !(cause_pending && entry_ctl[pm_regs_pkg::MODE_SEL_BIT] &&
                            entry_ctl[pm_regs_pkg::MGMT_GEN_BIT] &&
                            !entry_ctl[pm_regs_pkg::IRQ15_SEL_BIT]);
      irq15 <= cause_pending && entry_ctl[pm_regs_pkg::MODE_SEL_BIT] &&
               entry_ctl[pm_regs_pkg::IRQ15_SEL_BIT];
      low_power_active <= next_low_power;
      pm_irq <= |((irq_set | (irq_status & ~irq_clr)) & irq_enable);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_out_bit0_n <= 1'b1;
      sleep_out_bit1_n <= 1'b1;
      sleep_out_bit2_n <= 1'b1;
      wake_out_bit1_n <= 1'b1;
      wake_out_bit2_n <= 1'b1;
    end else begin
      sleep_out_bit0_n <= !(next_low_power && low_power_output_config[pm_regs_pkg::OUT_BIT0]);
      sleep_out_bit1_n <= !(next_low_power && low_power_output_config[pm_regs_pkg::OUT_BIT1]);
      sleep_out_bit2_n <= !(next_low_power && low_power_output_config[pm_regs_pkg::OUT_BIT2]);
      wake_out_bit1_n <= !(!next_low_power && normal_return_output_config[pm_regs_pkg::OUT_BIT1]);
      wake_out_bit2_n <= !(!next_low_power && normal_return_output_config[pm_regs_pkg::OUT_BIT2]);
    end
  end

endmodule

/* low_power_mode_control_regs_props.sv */
`timescale 1ns/1ps
module low_power_mode_control_regs_props #(
  parameter longint cycles_per_second = 10,
  parameter longint long_pulse_cycles = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pm_regs_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic activity_wake,
  input wire logic periph_power_en_n,
  input wire logic mgmt_interrupt_n,
  input wire logic irq15,
  input wire logic low_power_active
);
  logic [7:0] sh;
  logic acc;
  logic mg_ok;
  logic i15_ok;
  assign acc = psel && penable;
  assign mg_ok = sh[7] && sh[5] && !sh[4];
  assign i15_ok = sh[7] && sh[4];
  // Shadow of the control byte as software last wrote it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh <= 8'h00;
    end else if (acc && pwrite && paddr == 10'h380) begin
      sh <= pwdata[7:0];
    end
  end
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_force;
    acc && pwrite && paddr == 10'h384 && pwdata[3] && sh[0] && !low_power_active;
  endsequence
  sequence s_wake;
    low_power_active && activity_wake;
  endsequence
  AST_READY: assert property (psel |-> pready)
    else $error("pready low in a transfer");
  AST_SLVERR: assert property (acc |-> pslverr == !(paddr[9:2] inside {8'he0, 8'he1, [8'hea:8'hf2]}))
    else $error("pslverr wrong for address");
  AST_PERIPH_POWER_EN_N: assert property (periph_power_en_n |-> low_power_active && (sh[6] || $past(sh[6])))
    else $error("peripheral power off when not allowed");
  AST_MGMT: assert property (!mgmt_interrupt_n |-> mg_ok || $past(mg_ok))
    else $error("management interrupt in wrong mode");
  AST_IRQ15: assert property (irq15 |-> i15_ok || $past(i15_ok))
    else $error("irq15 in wrong mode");
  AST_STATUS: assert property (
    acc && !pwrite && paddr == 10'h380 && $past(low_power_active, 2) == $past(low_power_active)
    |-> prdata[3] == !$past(low_power_active))
    else $error("mode status bit wrong");
  AST_FORCE: assert property (s_force |=> low_power_active)
    else $error("forced entry not taken");
  AST_WAKE: assert property (s_wake |=> !low_power_active && !periph_power_en_n)
    else $error("wake not taken");
endmodule

/* pm_regs_pkg.sv */
package pm_regs_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] ENTRY_CTL_IDX = 8'he0;
  localparam logic [7:0] MODE_TIMER_IDX = 8'he1;
  localparam logic [7:0] LOW_POWER_OUT_IDX = 8'hea;
  localparam logic [7:0] NORMAL_OUT_IDX = 8'heb;
  localparam logic [7:0] SCRATCH_ONE_IDX = 8'hec;
  localparam logic [7:0] SCRATCH_TWO_IDX = 8'hed;
  localparam logic [7:0] WAKE_OPT_IDX = 8'hee;
  localparam logic [7:0] COMPANION_IDX = 8'hef;
  localparam logic [7:0] IRQ_STATUS_IDX = 8'hf0;
  localparam logic [7:0] IRQ_ENABLE_IDX = 8'hf1;
  localparam logic [7:0] IRQ_CLEAR_IDX = 8'hf2;

  localparam int ADDR_W = 10;

  // Main power-control register fields.
  localparam int MODE_SEL_BIT = 7;
  localparam int PERIPH_GEN_BIT = 6;
  localparam int MGMT_GEN_BIT = 5;
  localparam int IRQ15_SEL_BIT = 4;
  localparam int NORMAL_STAT_BIT = 3;
  localparam int TIMER_BIT = 2;
  localparam int EXT_BIT = 1;
  localparam int FORCE_EN_BIT = 0;

  // Neighbouring mode register fields.
  localparam int EXT_RELOAD_BIT = 6;
  localparam int PULSE_WIDTH_BIT = 5;
  localparam int POLARITY_BIT = 4;
  localparam int FORCE_BIT = 3;
  localparam int TIMER_SEL_LSB = 0;
  localparam int TIMER_SEL_W = 3;

  // Output-config register fields.
  localparam int OUT_BIT0 = 0;
  localparam int OUT_BIT1 = 1;
  localparam int OUT_BIT2 = 2;

  // Interrupt status fields.
  localparam int IRQ_ENTRY_BIT = 0;
  localparam int IRQ_WAKE_BIT = 1;
  localparam int IRQ_W = 2;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

  // Timing.
  localparam int CLK_PERIOD_PS = 8000;
  localparam int SHORT_PULSE_NS = 100;
  localparam int LONG_PULSE_MS = 5;
  localparam int SHORT_PULSE_CYCLES = (SHORT_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam longint LONG_PULSE_CYCLES = (64'(LONG_PULSE_MS) * 1000000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam longint CYCLES_PER_SECOND = 64'd1000000000000 / CLK_PERIOD_PS;

  // Event-timer periods in seconds, by select code.
  localparam int TIMER_S_0 = 15;
  localparam int TIMER_S_1 = 120;
  localparam int TIMER_S_2 = 300;
  localparam int TIMER_S_3 = 900;
  localparam int TIMER_S_4 = 1800;
  localparam int TIMER_S_5 = 2700;
  localparam int TIMER_S_6 = 3600;
  localparam int TIMER_S_7 = 14400;
  localparam int SECONDS_W = 14;

  typedef enum logic {normal_state, low_power_state} mode_state_type;

endpackage

/* tb_low_power_mode_control_regs.sv */
`timescale 1ns/1ps
module tb_low_power_mode_control_regs;
  localparam logic [7:0] CTL = pm_regs_pkg::ENTRY_CTL_IDX;
  localparam logic [7:0] MOD = pm_regs_pkg::MODE_TIMER_IDX;
  localparam logic [7:0] IST = pm_regs_pkg::IRQ_STATUS_IDX;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [pm_regs_pkg::ADDR_W-1:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, ext_n, act, periph_power_en_n_n, mgmt_n, irq15, s0_n, s1_n, s2_n, w1_n, w2_n, lp, pm_irq;
  logic pulse_req = 1'b0;
  logic wake_req = 1'b0;
  logic [7:0] pulse_len = 8'h00;
  logic [31:0] seed = 32'h00003609;
  logic [31:0] rd;
  logic err;
  logic [7:0] ea, eb, v, c;
  logic [7:0] idxs [6] = '{8'hea, 8'heb, 8'hec, 8'hed, 8'hee, 8'hef};
  logic [7:0] modes [5] = '{8'h40, 8'he0, 8'ha0, 8'h90, 8'h50};
  int num_errors = 0;
  int samples_checked = 0;
  int n;
  always #4 pclk = ~pclk;
  low_power_mode_control_regs #(.cycles_per_second(10), .long_pulse_cycles(20)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_power_event_in_n(ext_n),
    .activity_wake(act), .periph_power_en_n(periph_power_en_n_n), .mgmt_interrupt_n(mgmt_n), .irq15(irq15),
    .sleep_out_bit0_n(s0_n), .sleep_out_bit1_n(s1_n), .sleep_out_bit2_n(s2_n), .wake_out_bit1_n(w1_n),
    .wake_out_bit2_n(w2_n), .low_power_active(lp), .pm_irq(pm_irq));
  far_side_model u_far (.pclk(pclk), .pulse_req(pulse_req), .pulse_len(pulse_len), .wake_req(wake_req),
    .ext_power_event_in_n(ext_n), .activity_wake(act));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] exp_ctl(input logic [7:0] m, input logic low, input logic [2:0] cause);
    return {24'h0, m[7:4], !low, cause};
  endfunction
  function automatic logic [8:0] exp_pins(input logic [7:0] m, input logic low, input logic cause);
    return {low & m[6], !(cause & m[7] & m[5] & !m[4]), cause & m[7] & m[4], low,
      low ? ~ea[2:0] : 3'b111, low ? 2'b11 : ~eb[2:1]};
  endfunction
  task automatic finish_test();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin
      num_errors++;
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_lp(input logic want, input int max);
    n = 0;
    while (lp !== want && n < max) begin
      @(posedge pclk);
      n++;
    end
    if (lp !== want) begin
      num_errors++;
      finish_test();
    end
  endtask
  task automatic wake();
    wake_req <= 1'b1;
    @(posedge pclk);
    wake_req <= 1'b0;
    wait_lp(1'b0, 8);
  endtask
  task automatic pulse(input logic [7:0] len);
    pulse_len <= len;
    pulse_req <= 1'b1;
    @(posedge pclk);
    pulse_req <= 1'b0;
  endtask
  task automatic check_pins(input logic [7:0] m, input logic low, input logic cause);
    repeat (2) @(posedge pclk);
    check({23'h0, periph_power_en_n_n, mgmt_n, irq15, lp, s2_n, s1_n, s0_n, w2_n, w1_n}, {23'h0, exp_pins(m, low, cause)});
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CTL, 8'h00);
    check(rd, exp_ctl(8'h00, 1'b0, 3'b000));
    foreach (idxs[i]) begin
      apb(1'b0, idxs[i], 8'h00);
      check(rd, 32'h0);
      v = 8'(rnd());
      apb(1'b1, idxs[i], v);
      apb(1'b0, idxs[i], 8'h00);
      check(rd, {24'h0, v});
      if (i == 0) ea = v;
      if (i == 1) eb = v;
    end
    apb(1'b1, 8'he5, 8'hff);
    apb(1'b0, 8'he5, 8'h00);
    check({rd[30:0], err}, 32'h1);
    foreach (modes[i]) begin
      c = modes[i] | 8'h01;
      apb(1'b1, pm_regs_pkg::IRQ_ENABLE_IDX, i[0] ? 8'h03 : 8'h00);
      apb(1'b1, CTL, c);
      apb(1'b1, MOD, 8'h00);
      check_pins(c, 1'b0, 1'b0);
      apb(1'b1, MOD, 8'h08);
      wait_lp(1'b1, 8);
      check_pins(c, 1'b1, 1'b1);
      check({31'h0, pm_irq}, {31'h0, i[0]});
      apb(1'b0, CTL, 8'h00);
      check(rd, exp_ctl(c, 1'b1, 3'b001));
      wake();
      check_pins(c, 1'b0, 1'b1);
      apb(1'b0, IST, 8'h00);
      check(rd, 32'h3);
      apb(1'b1, pm_regs_pkg::IRQ_CLEAR_IDX, 8'h03);
      apb(1'b0, IST, 8'h00);
      check({rd[30:0], pm_irq}, 32'h0);
      apb(1'b1, CTL, c & 8'hf0);
      apb(1'b1, MOD, 8'h08);
      check_pins(c, 1'b0, 1'b0);
      apb(1'b0, CTL, 8'h00);
      check(rd, exp_ctl(c, 1'b0, 3'b000));
    end
    apb(1'b1, MOD, 8'h00);
    apb(1'b1, CTL, 8'h40);
    pulse(8'd30);
    repeat (40) @(posedge pclk);
    check({31'h0, lp}, 32'h0);
    apb(1'b1, CTL, 8'h42);
    pulse(8'd8);
    repeat (40) @(posedge pclk);
    check({31'h0, lp}, 32'h0);
    pulse(8'd14 + 8'(rnd() % 20));
    wait_lp(1'b1, 60);
    apb(1'b0, CTL, 8'h00);
    check(rd, exp_ctl(8'h42, 1'b1, 3'b010));
    wake();
    apb(1'b1, CTL, 8'h44);
    wake();
    wait_lp(1'b1, 400);
    check({31'h0, (n >= 135 && n <= 170)}, 32'h1);
    apb(1'b0, CTL, 8'h00);
    check(rd, exp_ctl(8'h44, 1'b1, 3'b100));
    apb(1'b1, CTL, 8'h40);
    apb(1'b1, MOD, 8'h68);
    apb(1'b0, MOD, 8'h00);
    check(rd, 32'h60);
    pulse(8'd15);
    repeat (40) @(posedge pclk);
    check({31'h0, lp}, 32'h1);
    pulse(8'd25);
    wait_lp(1'b0, 40);
    check({31'h0, periph_power_en_n_n}, 32'h0);
    // Let the long pulse end and the filter clear before the polarity flips.
    repeat (10) @(posedge pclk);
    apb(1'b1, CTL, 8'h42);
    apb(1'b1, MOD, 8'h10);
    wait_lp(1'b1, 40);
    apb(1'b0, CTL, 8'h00);
    check(rd, exp_ctl(8'h42, 1'b1, 3'b010));
    apb(1'b1, MOD, 8'h01);
    apb(1'b1, CTL, 8'h04);
    wake();
    wait_lp(1'b1, 1400);
    check({31'h0, (n >= 1190 && n <= 1220)}, 32'h1);
    apb(1'b0, CTL, 8'h00);
    check(rd, exp_ctl(8'h04, 1'b1, 3'b100));
    finish_test();
  end
endmodule
bind low_power_mode_control_regs low_power_mode_control_regs_props #(
  .cycles_per_second(cycles_per_second), .long_pulse_cycles(long_pulse_cycles)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .activity_wake(activity_wake),
  .periph_power_en_n(periph_power_en_n), .mgmt_interrupt_n(mgmt_interrupt_n), .irq15(irq15),
  .low_power_active(low_power_active));
